// *** rx_port_map.svh ***
// register offsets, field positions, reset values and strap layout
`ifndef RX_PORT_MAP_SVH
`define RX_PORT_MAP_SVH

`define PORT_SELECT_OFFSET 8'h4c
`define ALIAS_SLOT_6_OFFSET 8'h6b
`define ALIAS_SLOT_7_OFFSET 8'h6c
`define PORT_INPUT_CONFIG_OFFSET 8'h6d

`define PORT_SELECT_RESET 8'h01
`define SEL_WRITE_P0_BIT 0
`define SEL_WRITE_P1_BIT 1
`define SEL_READ_BIT 4

`define ALIAS_SLOT_RESET 8'h00
`define ALIAS_ADDR_MSB 7
`define ALIAS_ADDR_LSB 1
`define ALIAS_AUTO_ACK_BIT 0

`define PORT_CONFIG_RESET 8'h78
`define CFG_FIRST_FRAME_BIT 7
`define CFG_FRAME_BEGIN_BIT 6
`define CFG_PASS_CKSUM_BIT 5
`define CFG_PASS_HEADER_BIT 4
`define CFG_PASS_LENGTH_BIT 3
`define CFG_COAX_BIT 2
`define CFG_FORMAT_MSB 1
`define CFG_FORMAT_LSB 0

`define FIRST_FRAME_NUMBER 16'h0001
`define STRAP_COAX_BIT 2

`endif

// *** rx_port_pkg.sv ***
// types shared by the receive-port configuration logic
package rx_port_pkg;

	typedef enum logic [1:0] {
		FORMAT_CSI = 2'h0,
		FORMAT_RAW12_50 = 2'h1,
		FORMAT_RAW12_75 = 2'h2,
		FORMAT_RAW10_100 = 2'h3
	} rx_format_type;

	// reset loads wait any; gray along wait first -> wait any -> open
	typedef enum logic [1:0] {
		GATE_OPEN = 2'h0,
		GATE_WAIT_ANY = 2'h1,
		GATE_WAIT_ONE = 2'h3
	} gate_state_type;

endpackage

// *** alias_slot.sv ***
// one alias slot decoder: match and auto-acknowledge enable
`include "rx_port_map.svh"

module alias_slot (
	input wire logic [7:0] slot_value,
	input wire logic [6:0] bus_addr,
	output logic hit,
	output logic auto_ack_en
);
	logic [6:0] alias_addr;

	assign alias_addr = slot_value[`ALIAS_ADDR_MSB:`ALIAS_ADDR_LSB];
	// a zero alias never decodes
	assign hit = (alias_addr != 7'h00) && (alias_addr == bus_addr);
	assign auto_ack_en = slot_value[`ALIAS_AUTO_ACK_BIT];

endmodule // alias_slot

// *** rx_port_alias_and_input_config.sv ***
// per-port alias decode, packet acceptance and input configuration
// Contract
// - one register copy per port, chosen by select
// - matching alias remaps to remote target address
// - zero alias disables that slot
// - auto-ack bit acknowledges writes to target
// - first-frame hold: drop until frame one
// - frame-begin hold: drop until any frame start
// - csi mode: checksum-bad packets forwarded only when enabled
// - csi mode: header-bad packets forwarded only when enabled
// - csi mode: length-bad packets forwarded only when enabled
// - raw mode: bit three drops short line
// - cable bit: zero twisted pair, one coax
// - cable and format defaults from strap
// - format field selects csi or raw mode
`include "rx_port_map.svh"

module rx_port_alias_and_input_config
	import rx_port_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic i2c_addr_valid,
	input wire logic [6:0] i2c_addr,
	input wire logic i2c_is_write,
	input wire logic [6:0] remote_id_p0_s6,
	input wire logic [6:0] remote_id_p0_s7,
	input wire logic [6:0] remote_id_p1_s6,
	input wire logic [6:0] remote_id_p1_s7,
	output logic remap_hit,
	output logic [6:0] remap_addr,
	output logic remap_port,
	output logic remap_write,
	output logic auto_ack,
	input wire logic link_lock_0,
	input wire logic link_lock_1,
	input wire logic pkt_valid,
	input wire logic pkt_port,
	input wire logic pkt_frame_begin,
	input wire logic [15:0] pkt_frame_num,
	input wire logic pkt_cksum_err,
	input wire logic pkt_header_err,
	input wire logic pkt_length_err,
	input wire logic pkt_short_first_line,
	output logic pkt_accept,
	output logic pkt_reject,
	input wire logic power_down_release,
	input wire logic [2:0] mode_strap,
	output logic cable_coax_0,
	output logic cable_coax_1,
	output logic [1:0] serial_input_format_0,
	output logic [1:0] serial_input_format_1
);

	logic [7:0] port_select_reg;
	logic [7:0] remote_alias_slot_reg [0:1][0:1];
	logic [7:0] port_input_config_reg [0:1];
	gate_state_type gate_reg [0:1];
	gate_state_type gate_next [0:1];
	logic [1:0] hit [0:1];
	logic [1:0] auto_en [0:1];
	logic [6:0] remote_id [0:1][0:1];
	logic [1:0] pdb_sync_reg;
	logic pdb_seen_reg;
	logic [2:0] strap_meta_reg;
	logic [2:0] strap_sync_reg;
	logic [1:0] lock;
	logic strap_load;
	logic any_hit;
	logic hit_port;
	logic hit_auto;
	logic [6:0] hit_id;
	logic accept_next;
	logic [7:0] cfg_pkt;
	rx_format_type pkt_format;

	assign remote_id[0][0] = remote_id_p0_s6;
	assign remote_id[0][1] = remote_id_p0_s7;
	assign remote_id[1][0] = remote_id_p1_s6;
	assign remote_id[1][1] = remote_id_p1_s7;
	assign lock = {link_lock_1, link_lock_0};

	// pins are asynchronous: two flops before anything looks at them
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pdb_sync_reg <= 2'h0;
			strap_meta_reg <= 3'h0;
			strap_sync_reg <= 3'h0;
		end else if (ce) begin
			pdb_sync_reg <= {pdb_sync_reg[0], power_down_release};
			strap_meta_reg <= mode_strap;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// sample the strap once, on the first rising release after reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pdb_seen_reg <= 1'b0;
		end else if (ce && pdb_sync_reg[1]) begin
			pdb_seen_reg <= 1'b1;
		end
	end
	assign strap_load = pdb_sync_reg[1] && !pdb_seen_reg;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			port_select_reg <= `PORT_SELECT_RESET;
		end else if (ce && reg_wr && reg_addr == `PORT_SELECT_OFFSET) begin
			port_select_reg <= reg_wdata;
		end
	end

	// writes land in every port copy enabled by the select register
	always_ff @(posedge core_clk) begin
		for (int p = 0; p < 2; p++) begin
			if (rst) begin
				remote_alias_slot_reg[p][0] <= `ALIAS_SLOT_RESET;
				remote_alias_slot_reg[p][1] <= `ALIAS_SLOT_RESET;
				port_input_config_reg[p] <= `PORT_CONFIG_RESET;
			end else if (ce) begin
				if (reg_wr && port_select_reg[p]) begin
					case (reg_addr)
						`ALIAS_SLOT_6_OFFSET:
							remote_alias_slot_reg[p][0] <= reg_wdata;
						`ALIAS_SLOT_7_OFFSET:
							remote_alias_slot_reg[p][1] <= reg_wdata;
						`PORT_INPUT_CONFIG_OFFSET:
							port_input_config_reg[p] <= reg_wdata;
						default: ;
					endcase
				end
				// strap wins over a same-cycle write: it is the power-up default
				if (strap_load) begin
					port_input_config_reg[p][`CFG_COAX_BIT] <=
						strap_sync_reg[`STRAP_COAX_BIT];
					port_input_config_reg[p][`CFG_FORMAT_MSB:`CFG_FORMAT_LSB] <=
						strap_sync_reg[1:0];
				end
			end
		end
	end

	// reads come from the copy chosen by the read select bit
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce && reg_rd) begin
			case (reg_addr)
				`PORT_SELECT_OFFSET:
					reg_rdata <= port_select_reg;
				`ALIAS_SLOT_6_OFFSET:
					reg_rdata <= remote_alias_slot_reg[port_select_reg[
						`SEL_READ_BIT]][0];
				`ALIAS_SLOT_7_OFFSET:
					reg_rdata <= remote_alias_slot_reg[port_select_reg[
						`SEL_READ_BIT]][1];
				`PORT_INPUT_CONFIG_OFFSET:
					reg_rdata <= port_input_config_reg[port_select_reg[
						`SEL_READ_BIT]];
				default:
					reg_rdata <= 8'h00;
			endcase
		end
	end

	for (genvar p = 0; p < 2; p++) begin : g_port
		for (genvar s = 0; s < 2; s++) begin : g_slot
			alias_slot u_slot (
				.slot_value(remote_alias_slot_reg[p][s]),
				.bus_addr(i2c_addr),
				.hit(hit[p][s]),
				.auto_ack_en(auto_en[p][s])
			);
		end
	end

	// lowest port, then lowest slot, wins if aliases overlap
	always_comb begin
		any_hit = 1'b0;
		hit_port = 1'b0;
		hit_auto = 1'b0;
		hit_id = 7'h00;
		for (int p = 1; p >= 0; p--) begin
			for (int s = 1; s >= 0; s--) begin
				if (hit[p][s]) begin
					any_hit = 1'b1;
					hit_port = 1'(p);
					hit_auto = auto_en[p][s];
					hit_id = remote_id[p][s];
				end
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			remap_hit <= 1'b0;
			remap_addr <= 7'h00;
			remap_port <= 1'b0;
			remap_write <= 1'b0;
			auto_ack <= 1'b0;
		end else if (ce) begin
			remap_hit <= i2c_addr_valid && any_hit;
			remap_addr <= hit_id;
			remap_port <= hit_port;
			remap_write <= i2c_is_write;
			// no lock or remote answer in the term: acked here
			auto_ack <= i2c_addr_valid && any_hit && i2c_is_write && hit_auto;
		end
	end

	assign cfg_pkt = port_input_config_reg[pkt_port];
	assign pkt_format = rx_format_type'(cfg_pkt[`CFG_FORMAT_MSB:
		`CFG_FORMAT_LSB]);

	// gate re-arms while the link is down, opens on the wanted start
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			gate_next[p] = gate_reg[p];
			if (!lock[p]) begin
				if (port_input_config_reg[p][`CFG_FIRST_FRAME_BIT]) begin
					gate_next[p] = GATE_WAIT_ONE;
				end else if (port_input_config_reg[p][`CFG_FRAME_BEGIN_BIT]) begin
					gate_next[p] = GATE_WAIT_ANY;
				end else begin
					gate_next[p] = GATE_OPEN;
				end
			end else if (pkt_valid && pkt_port == 1'(p) && pkt_frame_begin) begin
				case (gate_reg[p])
					GATE_WAIT_ONE:
						if (pkt_frame_num == `FIRST_FRAME_NUMBER) begin
							gate_next[p] = GATE_OPEN;
						end
					GATE_WAIT_ANY:
						gate_next[p] = GATE_OPEN;
					GATE_OPEN:
						gate_next[p] = GATE_OPEN;
					default:
						gate_next[p] = GATE_OPEN;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		for (int p = 0; p < 2; p++) begin
			if (rst) begin
				gate_reg[p] <= GATE_WAIT_ANY;
			end else if (ce) begin
				gate_reg[p] <= gate_next[p];
			end
		end
	end

	always_comb begin
		accept_next = 1'b1;
		case (gate_reg[pkt_port])
			GATE_WAIT_ONE:
				accept_next = pkt_frame_begin &&
					pkt_frame_num == `FIRST_FRAME_NUMBER;
			GATE_WAIT_ANY:
				accept_next = pkt_frame_begin;
			default:
				accept_next = 1'b1;
		endcase
		if (pkt_format == FORMAT_CSI) begin
			if (pkt_cksum_err && !cfg_pkt[`CFG_PASS_CKSUM_BIT]) begin
				accept_next = 1'b0;
			end
			if (pkt_header_err && !cfg_pkt[`CFG_PASS_HEADER_BIT]) begin
				accept_next = 1'b0;
			end
			if (pkt_length_err && !cfg_pkt[`CFG_PASS_LENGTH_BIT]) begin
				accept_next = 1'b0;
			end
		end else if (pkt_short_first_line && cfg_pkt[`CFG_PASS_LENGTH_BIT]) begin
			accept_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pkt_accept <= 1'b0;
			pkt_reject <= 1'b0;
		end else if (ce) begin
			pkt_accept <= pkt_valid && accept_next;
			pkt_reject <= pkt_valid && !accept_next;
		end
	end

	// mode outputs are the register bits themselves
	assign cable_coax_0 = port_input_config_reg[0][`CFG_COAX_BIT];
	assign cable_coax_1 = port_input_config_reg[1][`CFG_COAX_BIT];
	assign serial_input_format_0 =
		port_input_config_reg[0][`CFG_FORMAT_MSB:`CFG_FORMAT_LSB];
	assign serial_input_format_1 =
		port_input_config_reg[1][`CFG_FORMAT_MSB:`CFG_FORMAT_LSB];

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	property p_port_route;
		ce && reg_wr && reg_addr == `ALIAS_SLOT_6_OFFSET &&
			port_select_reg == 8'h02 && !strap_load
			|=> remote_alias_slot_reg[1][0] == $past(reg_wdata) &&
			remote_alias_slot_reg[0][0] == $past(remote_alias_slot_reg[0][0]);
	endproperty
	a_port_route: assert property (p_port_route)
		else $error("write reached the wrong port copy");

	property p_alias_remap;
		ce && i2c_addr_valid && any_hit
			|=> remap_hit && remap_addr == $past(hit_id);
	endproperty
	a_alias_remap: assert property (p_alias_remap)
		else $error("alias match not remapped to remote id");

	property p_alias_zero;
		ce && i2c_addr_valid && i2c_addr == 7'h00 |=> !remap_hit;
	endproperty
	a_alias_zero: assert property (p_alias_zero)
		else $error("zero alias decoded");

	property p_auto_ack;
		ce && i2c_addr_valid && any_hit && i2c_is_write && hit_auto
			|=> auto_ack && remap_hit;
	endproperty
	a_auto_ack: assert property (p_auto_ack)
		else $error("auto acknowledge missing");

	property p_auto_ack_local;
		ce && i2c_addr_valid && !link_lock_0 && !link_lock_1 &&
			any_hit && i2c_is_write && hit_auto |-> ##1 auto_ack;
	endproperty
	a_auto_ack_local: assert property (p_auto_ack_local)
		else $error("auto acknowledge waited on the link");

	property p_wait_first;
		ce && pkt_valid && gate_reg[pkt_port] == GATE_WAIT_ONE &&
			!(pkt_frame_begin && pkt_frame_num == 16'h0001) |=> !pkt_accept;
	endproperty
	a_wait_first: assert property (p_wait_first)
		else $error("packet accepted before frame one");

	property p_wait_any;
		ce && pkt_valid && gate_reg[pkt_port] == GATE_WAIT_ANY &&
			!pkt_frame_begin |=> pkt_reject;
	endproperty
	a_wait_any: assert property (p_wait_any)
		else $error("packet accepted before frame start");

	property p_cksum;
		ce && pkt_valid && pkt_format == FORMAT_CSI && pkt_cksum_err &&
			!cfg_pkt[5] |=> !pkt_accept;
	endproperty
	a_cksum: assert property (p_cksum)
		else $error("checksum-bad packet forwarded");

	property p_header;
		ce && pkt_valid && pkt_format == FORMAT_CSI && pkt_header_err &&
			!cfg_pkt[4] |=> !pkt_accept;
	endproperty
	a_header: assert property (p_header)
		else $error("header-bad packet forwarded");

	property p_length;
		ce && pkt_valid && pkt_format == FORMAT_CSI && pkt_length_err &&
			!cfg_pkt[3] |=> pkt_reject;
	endproperty
	a_length: assert property (p_length)
		else $error("length-bad packet forwarded");

	property p_short_line;
		ce && pkt_valid && pkt_format != FORMAT_CSI &&
			gate_reg[pkt_port] == GATE_OPEN
			|=> pkt_reject == $past(pkt_short_first_line && cfg_pkt[3]);
	endproperty
	a_short_line: assert property (p_short_line)
		else $error("short first line handling wrong");

	property p_strap;
		ce && strap_load |=> cable_coax_0 == $past(strap_sync_reg[2]) &&
			serial_input_format_1 == $past(strap_sync_reg[1:0]);
	endproperty
	a_strap: assert property (p_strap)
		else $error("strap default not loaded");

endmodule // rx_port_alias_and_input_config

// *** remote_link_model.sv ***
// far-side stand-in: forward link lock and remote target ids
module remote_link_model (
	input wire logic core_clk,
	input wire logic [1:0] lock_want,
	output logic link_lock_0,
	output logic link_lock_1,
	output logic [6:0] remote_id_p0_s6,
	output logic [6:0] remote_id_p0_s7,
	output logic [6:0] remote_id_p1_s6,
	output logic [6:0] remote_id_p1_s7
);
	timeunit 1ns;
	timeprecision 1ps;
	// lock follows a cycle late, as a real link would settle
	always_ff @(posedge core_clk) begin
		link_lock_0 <= lock_want[0];
		link_lock_1 <= lock_want[1];
	end
	assign remote_id_p0_s6 = 7'h50;
	assign remote_id_p0_s7 = 7'h51;
	assign remote_id_p1_s6 = 7'h60;
	assign remote_id_p1_s7 = 7'h61;
endmodule // remote_link_model

// *** rx_port_alias_and_input_config_test.sv ***
// self-checking bench for the receive-port configuration block
module rx_port_alias_and_input_config_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, iv = 0, iw = 0;
	logic pv = 0, fs = 0, pdr = 0, acc, rej, hit, ack, rport, rwr;
	logic ll0, ll1, cx0, cx1, en = 1, pp = 0;
	logic [7:0] ra = 0, wd = 0, rdata;
	logic [6:0] ia = 0, raddr, id06, id07, id16, id17;
	logic [15:0] fnum = 0;
	logic [3:0] perr = 0;
	logic [2:0] strap = 3'h6;
	logic [1:0] lw = 0, f0, f1;
	int fail_count = 0, samples_checked = 0;
	always #2.5 core_clk = ~core_clk;
	remote_link_model u_remote_link_model (.core_clk(core_clk),
		.lock_want(lw), .link_lock_0(ll0), .link_lock_1(ll1),
		.remote_id_p0_s6(id06), .remote_id_p0_s7(id07),
		.remote_id_p1_s6(id16), .remote_id_p1_s7(id17));
	rx_port_alias_and_input_config u_rx_port_alias_and_input_config (
		.core_clk(core_clk), .rst(rst), .ce(en), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(ra), .reg_wdata(wd), .reg_rdata(rdata),
		.i2c_addr_valid(iv), .i2c_addr(ia), .i2c_is_write(iw),
		.remote_id_p0_s6(id06), .remote_id_p0_s7(id07),
		.remote_id_p1_s6(id16), .remote_id_p1_s7(id17),
		.remap_hit(hit), .remap_addr(raddr), .remap_port(rport),
		.remap_write(rwr), .auto_ack(ack), .link_lock_0(ll0),
		.link_lock_1(ll1), .pkt_valid(pv), .pkt_port(pp),
		.pkt_frame_begin(fs), .pkt_frame_num(fnum),
		.pkt_cksum_err(perr[0]), .pkt_header_err(perr[1]),
		.pkt_length_err(perr[2]), .pkt_short_first_line(perr[3]),
		.pkt_accept(acc), .pkt_reject(rej), .power_down_release(pdr),
		.mode_strap(strap), .cable_coax_0(cx0), .cable_coax_1(cx1),
		.serial_input_format_0(f0), .serial_input_format_1(f1));

	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1;
		ra <= a;
		wd <= d;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rdc(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd <= 1;
		ra <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 check(rdata, exp);
	endtask
	// a miss drives remap_addr to zero, but only hits compare it
	task i2c(input logic [6:0] a, input logic w, input logic [1:0] hk,
		input logic [7:0] pid);
		@(posedge core_clk);
		iv <= 1;
		ia <= a;
		iw <= w;
		@(posedge core_clk);
		iv <= 0;
		#1 check({hit, ack}, hk);
		if (hk[1]) check({rport, raddr, 7'h0, rwr}, {pid, 7'h0, w});
	endtask
	task pk(input logic b, input logic [15:0] n, input logic [3:0] e,
		input logic ok);
		@(posedge core_clk);
		pv <= 1;
		fs <= b;
		fnum <= n;
		perr <= e;
		@(posedge core_clk);
		pv <= 0;
		#1 check({acc, rej}, {ok, !ok});
	endtask
	task relock;
		@(posedge core_clk);
		lw <= 0;
		repeat (3) @(posedge core_clk);
		lw <= 1;
		repeat (3) @(posedge core_clk);
	endtask

	task t_strap;
		@(posedge core_clk);
		pdr <= 1;
		repeat (6) @(posedge core_clk);
		#1 check({cx0, cx1, f0, f1}, 6'h3a);
		rdc(8'h4c, 8'h01);
		rdc(8'h6b, 8'h00);
		rdc(8'h6c, 8'h00);
		rdc(8'h6d, 8'h7e);
		$display("test strap done");
	endtask
	task t_ports;
		wr(8'h4c, 8'h02);
		wr(8'h6d, 8'h55);
		wr(8'h4c, 8'h01);
		rdc(8'h6d, 8'h7e);
		wr(8'h4c, 8'h10);
		rdc(8'h6d, 8'h55);
		#1 check({cx0, cx1, f0, f1}, 6'h39);
		wr(8'h4c, 8'h01);
		// enable low: the write must not land
		en <= 0;
		wr(8'h6d, 8'h00);
		en <= 1;
		rdc(8'h6d, 8'h7e);
		$display("test ports done");
	endtask
	// link stays unlocked here: auto-ack must not wait on it
	task t_alias;
		wr(8'h6b, 8'h43);
		i2c(7'h21, 1, 2'b11, 8'h50);
		i2c(7'h21, 0, 2'b10, 8'h50);
		i2c(7'h22, 1, 2'b00, 8'h00);
		wr(8'h6b, 8'h42);
		i2c(7'h21, 1, 2'b10, 8'h50);
		wr(8'h6b, 8'h01);
		i2c(7'h00, 1, 2'b00, 8'h00);
		wr(8'h4c, 8'h02);
		wr(8'h6b, 8'h47);
		i2c(7'h23, 1, 2'b11, 8'he0);
		wr(8'h6c, 8'h45);
		i2c(7'h22, 1, 2'b11, 8'he1);
		wr(8'h4c, 8'h01);
		$display("test alias done");
	endtask
	task t_gate;
		wr(8'h6d, 8'h78);
		relock();
		pk(0, 0, 0, 0);
		pk(1, 5, 0, 1);
		pk(0, 0, 0, 1);
		pk(0, 0, 4'h1, 1);
		pk(0, 0, 4'h2, 1);
		pk(0, 0, 4'h4, 1);
		wr(8'h6d, 8'h40);
		pk(0, 0, 4'h1, 0);
		pk(0, 0, 4'h2, 0);
		pk(0, 0, 4'h4, 0);
		wr(8'h6d, 8'h80);
		relock();
		pk(1, 2, 0, 0);
		pk(0, 0, 0, 0);
		pk(1, 1, 0, 1);
		pk(0, 0, 0, 1);
		$display("test gate done");
	endtask
	task t_format;
		for (int i = 0; i < 4; i++) begin
			wr(8'h6c - 8'h01 + 8'h02, 8'h0c | 8'(i));
			#1 check({cx0, f0}, 3'h4 | 3'(i));
		end
		wr(8'h6d, 8'h09);
		#1 check({cx0, f0}, 3'h1);
		pk(0, 0, 4'h8, 0);
		pk(0, 0, 4'h7, 1);
		wr(8'h6d, 8'h01);
		// port one still unlocked and holding for a frame start
		pp <= 1;
		pk(0, 0, 4'h8, 0);
		pk(1, 0, 4'h8, 1);
		@(posedge core_clk);
		pp <= 0;
		pk(0, 0, 4'h8, 1);
		$display("test format done");
	endtask

	task results;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 0;
		t_strap();
		t_ports();
		t_alias();
		t_gate();
		t_format();
		results();
	end
	initial begin
		#(5000 * 5);
		fail_count++;
		results();
	end
endmodule // rx_port_alias_and_input_config_test
